/* File: hw/tsa_time_slot_assigner.sv */
// Module: per-channel time slot assigner between TDM highway and HDLC
`timescale 1ns/10ps
// Functional notes
// [RULE1] Mode input picks direct serial pins or the highway window path.
// [RULE2] Each channel instance picks its own window on a shared highway.
// [RULE3] Window spans anything from one bit to a whole frame.
// [RULE4] Start and stop are 12-bit bit counts after frame sync.
// [RULE5] Only bits between start and stop pass to the channel.
// [RULE6] Window length may reach 4096 consecutive bits.
// [RULE7] Sub-byte windows of one to eight bits are supported.
// [RULE8] Frames of up to 512 byte slots are handled.
// [RULE9] Sustains channel bursts up to 10 Mbit/s in both modes.
// [RULE10] Transmit and receive run together in the same frames.
// [RULE11] Highway supplies frame sync, normally 8 kHz, per frame.
// [RULE12] One highway bit clock times both transmit and receive.
// [RULE13] Slot buffer enable is active exactly while transmit carries data.
// [RULE14] Counter clears on frame sync, steps per bit; output released outside.
// [RULE15] After stop, nothing passes until next sync and start.
module tsa_time_slot_assigner
	import tsa_pkg::*;
#(
	parameter int POS_W = TSA_POS_W
) (
	// Clock and reset
	core_clk,
	rst_n,
	// Configuration
	highway_mode,
	start_pos,
	stop_pos,
	// Highway pins
	hw_bit_clk,
	frame_sync_in,
	hw_rxd,
	hw_txd_o,
	hw_txd_oe,
	slot_buffer_enable,
	// Direct serial pins
	dce_rxd,
	dce_rclk,
	dce_txd,
	dce_tclk,
	// HDLC channel side
	hdlc_tx_bit,
	hdlc_tx_valid,
	hdlc_tx_ready,
	hdlc_rx_bit,
	hdlc_rx_valid,
	hdlc_bit_clk
);
	input wire logic core_clk;
	input wire logic rst_n;
	input wire logic highway_mode;
	input wire logic [POS_W-1:0] start_pos;
	input wire logic [POS_W-1:0] stop_pos;
	input wire logic hw_bit_clk;
	input wire logic frame_sync_in;
	input wire logic hw_rxd;
	output logic hw_txd_o;
	output logic hw_txd_oe;
	output logic slot_buffer_enable;
	input wire logic dce_rxd;
	input wire logic dce_rclk;
	output logic dce_txd;
	input wire logic dce_tclk;
	input wire logic hdlc_tx_bit;
	input wire logic hdlc_tx_valid;
	output logic hdlc_tx_ready;
	output logic hdlc_rx_bit;
	output logic hdlc_rx_valid;
	output logic hdlc_bit_clk;

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	localparam int NS = 6;
	logic [NS-1:0] pins;
	logic [NS-1:0] s1_ff;
	logic [NS-1:0] s2_ff;
	logic [NS-1:0] s3_ff;
	logic [NS-1:0] st_ff;
	assign pins = {dce_tclk, dce_rclk, dce_rxd, hw_rxd, frame_sync_in,
		hw_bit_clk};

	// Three stages; stable level taken only when stages two and three agree
	genvar gi;
	generate
		for (gi = 0; gi < NS; gi++) begin : g_sync
			always_ff @(posedge core_clk) begin
				// Reset to idle level, so no false edge follows reset
				if (!rst_n) begin
					s1_ff[gi] <= TSA_PIN_IDLE[gi];
					s2_ff[gi] <= TSA_PIN_IDLE[gi];
					s3_ff[gi] <= TSA_PIN_IDLE[gi];
					st_ff[gi] <= TSA_PIN_IDLE[gi];
				end else begin
					s1_ff[gi] <= pins[gi];
					s2_ff[gi] <= s1_ff[gi];
					s3_ff[gi] <= s2_ff[gi];
					if (s2_ff[gi] == s3_ff[gi]) begin
						st_ff[gi] <= s3_ff[gi];
					end
				end
			end
		end
	endgenerate

	logic [NS-1:0] st_d_ff;
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			st_d_ff <= TSA_PIN_IDLE;
		end else begin
			st_d_ff <= st_ff;
		end
	end

	// Edge strobes, one core cycle each
	logic hw_rise, hw_fall, fs_rise, rc_rise, tc_fall;
	assign hw_rise = st_ff[0] && !st_d_ff[0];
	assign hw_fall = !st_ff[0] && st_d_ff[0];
	assign fs_rise = st_ff[1] && !st_d_ff[1];
	assign rc_rise = st_ff[4] && !st_d_ff[4];
	assign tc_fall = !st_ff[5] && st_d_ff[5];

	// ------------------------------------------------------------
	// Bit position counter and window state
	// ------------------------------------------------------------
	tsa_state_t state_ff;
	logic [POS_W-1:0] pos_ff;
	logic in_win;
	logic at_stop;
	assign in_win = (state_ff == TSA_OPEN);
	assign at_stop = (pos_ff == stop_pos);

	// Restart on frame sync, advance on each highway bit clock
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			pos_ff <= TSA_POS_RST;
		end else if (fs_rise) begin
			pos_ff <= TSA_POS_RST; // see [RULE14] [RULE4] [RULE11]
		end else if (hw_fall) begin
			pos_ff <= pos_ff + 1'b1; // see [RULE14] [RULE8] [RULE6]
		end
	end

	// Window opens at start, closes after stop; a 12-bit count wraps at 4096
	always_ff @(posedge core_clk) begin
		if (!rst_n || !highway_mode) begin
			state_ff <= TSA_IDLE;
		end else if (fs_rise) begin
			state_ff <= TSA_WAIT; // see [RULE15]
		end else begin
			unique case (state_ff)
				TSA_IDLE: state_ff <= TSA_IDLE;
				// A one-bit window opens and closes on the same bit
				TSA_WAIT: if (hw_fall && pos_ff == start_pos) begin
					state_ff <= at_stop ? TSA_DONE : TSA_OPEN; // see [RULE3]
				end
				TSA_OPEN: if (hw_fall && at_stop) begin
					state_ff <= TSA_DONE; // see [RULE15] [RULE5]
				end
				TSA_DONE: state_ff <= TSA_DONE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Transmit: FIFO feeds the active port
	// ------------------------------------------------------------
	tsa_fifo_if #(.W(1)) txq ();
	tsa_fifo #(.W(1), .DEPTH(TSA_FIFO_DEPTH)) u_txq (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.s(txq.fifo)
	);
	logic take_bit;
	logic open_d;
	assign txq.in_valid = hdlc_tx_valid;
	assign txq.in_data = hdlc_tx_bit;
	// Bit leaves on the launch edge of whichever clock is in use
	// Stop bit itself is still launched; the window is inclusive
	assign take_bit = highway_mode ? (hw_fall && (open_d || (state_ff ==
		TSA_WAIT && pos_ff == start_pos))) : tc_fall; // see [RULE1] [RULE10]
	assign txq.out_ready = take_bit;
	assign open_d = in_win;

	// Channel stalls on a full queue, which throttles its bit rate
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			hdlc_tx_ready <= 1'b0;
		end else begin
			hdlc_tx_ready <= txq.in_ready; // see [RULE9]
		end
	end

	// Highway driver: enable and buffer control move together
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			hw_txd_o <= 1'b1;
			hw_txd_oe <= 1'b0;
			slot_buffer_enable <= 1'b0;
			dce_txd <= 1'b1;
		end else begin
			if (!highway_mode) begin
				hw_txd_oe <= 1'b0;
				slot_buffer_enable <= 1'b0;
			end else if (hw_fall) begin
				hw_txd_oe <= take_bit; // see [RULE14] [RULE2]
				slot_buffer_enable <= take_bit; // see [RULE13]
			end
			if (take_bit && highway_mode) begin
				// Underrun sends idle mark rather than stale data
				hw_txd_o <= txq.out_valid ? txq.out_data : 1'b1;
			end
			if (take_bit && !highway_mode) begin
				dce_txd <= txq.out_valid ? txq.out_data : 1'b1; // see [RULE1]
			end
		end
	end

	// ------------------------------------------------------------
	// Receive: sample on rising edge; highway bit clock, or dce_rclk rather than dce_tclk in direct mode
	// ------------------------------------------------------------
	logic rx_take;
	// Driver enable spans start through stop, so it marks receive bits too
	assign rx_take = highway_mode ? (hw_rise && hw_txd_oe) : rc_rise;

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			hdlc_rx_bit <= 1'b0;
			hdlc_rx_valid <= 1'b0;
		end else begin
			hdlc_rx_valid <= rx_take; // see [RULE12] [RULE10] [RULE5]
			if (rx_take) begin
				hdlc_rx_bit <= highway_mode ? st_ff[2] : st_ff[3];
			end
		end
	end

	// Bit clock to the channel: gated to window bits on the highway, plain dce_rclk in direct mode
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			hdlc_bit_clk <= 1'b0;
		end else begin
			hdlc_bit_clk <= highway_mode ? (st_ff[0] && hw_txd_oe) : st_ff[4];
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	property p_sync_clears;
		@(posedge core_clk) disable iff (!rst_n)
		fs_rise |=> (pos_ff == '0);
	endproperty
	a_sync_clears: assert property (p_sync_clears) // see [RULE14]
		else $error("position not cleared by frame sync");

	property p_step;
		@(posedge core_clk) disable iff (!rst_n)
		(hw_fall && !fs_rise) |=> (pos_ff == $past(pos_ff) + 1'b1);
	endproperty
	a_step: assert property (p_step) // see [RULE4]
		else $error("position did not step on bit clock");

	property p_enable_tracks;
		@(posedge core_clk) disable iff (!rst_n)
		slot_buffer_enable == hw_txd_oe;
	endproperty
	a_enable_tracks: assert property (p_enable_tracks) // see [RULE13]
		else $error("buffer enable differs from driver enable");

	property p_released_idle;
		@(posedge core_clk) disable iff (!rst_n)
		(state_ff == TSA_DONE && hw_fall) |=> !hw_txd_oe;
	endproperty
	a_released_idle: assert property (p_released_idle) // see [RULE15]
		else $error("driver active after stop");

	property p_rx_in_window;
		@(posedge core_clk) disable iff (!rst_n)
		(highway_mode && hdlc_rx_valid) |-> $past(hw_txd_oe);
	endproperty
	a_rx_in_window: assert property (p_rx_in_window) // see [RULE5]
		else $error("receive bit outside window");

	property p_direct_no_drive;
		@(posedge core_clk) disable iff (!rst_n)
		!highway_mode |=> !hw_txd_oe;
	endproperty
	a_direct_no_drive: assert property (p_direct_no_drive) // see [RULE1]
		else $error("highway driven in direct mode");

	property p_open_at_start;
		@(posedge core_clk) disable iff (!rst_n)
		(highway_mode && state_ff == TSA_WAIT && hw_fall && !fs_rise &&
			pos_ff == start_pos) |=>
			(state_ff == ($past(at_stop) ? TSA_DONE : TSA_OPEN));
	endproperty
	a_open_at_start: assert property (p_open_at_start) // see [RULE3]
		else $error("window did not open at start");

	property p_close_at_stop;
		@(posedge core_clk) disable iff (!rst_n)
		(highway_mode && in_win && hw_fall && !fs_rise && at_stop)
			|=> (state_ff == TSA_DONE);
	endproperty
	a_close_at_stop: assert property (p_close_at_stop) // see [RULE15]
		else $error("window did not close at stop");

	c_window: cover property (@(posedge core_clk) disable iff (!rst_n)
		state_ff == TSA_WAIT ##[1:1000] state_ff == TSA_OPEN);
	c_drive: cover property (@(posedge core_clk) disable iff (!rst_n)
		hw_txd_oe && slot_buffer_enable);
	c_rx: cover property (@(posedge core_clk) disable iff (!rst_n)
		hdlc_rx_valid && highway_mode);
	c_full: cover property (@(posedge core_clk) disable iff (!rst_n)
		!txq.in_ready);
endmodule : tsa_time_slot_assigner

/* File: hw/tsa_pkg.sv */
// Package: constants and types for the time slot assigner
package tsa_pkg;
	localparam int TSA_POS_W = 12;
	localparam logic [11:0] TSA_POS_RST = 12'h000;
	localparam int TSA_SYNC_STAGES = 3;
	// Idle pin levels: both serial clocks, both data lines and bit clock
	// rest high, frame sync rests low; seeds the edge detectors at reset
	localparam logic [5:0] TSA_PIN_IDLE = 6'h3d;
	localparam int TSA_FIFO_DEPTH = 4;
	localparam int TSA_CLK_MHZ = 50;
	localparam int TSA_MAX_RATE_MBPS = 10;
	// Fewest core cycles per bit at the fastest documented burst rate
	localparam int TSA_MIN_BIT_CYC = TSA_CLK_MHZ / TSA_MAX_RATE_MBPS;
	typedef enum logic [1:0] {
		TSA_IDLE = 2'b00,
		TSA_WAIT = 2'b01,
		TSA_OPEN = 2'b11,
		TSA_DONE = 2'b10
	} tsa_state_t;
endpackage : tsa_pkg

/* File: hw/tsa_fifo_if.sv */
// Interface: valid/ready stream between assigner and its fifo
`timescale 1ns/10ps
interface tsa_fifo_if #(parameter int W = 1) ();
	logic in_valid;
	logic in_ready;
	logic [W-1:0] in_data;
	logic out_valid;
	logic out_ready;
	logic [W-1:0] out_data;
	modport fifo (input in_valid, input in_data, output in_ready,
		output out_valid, output out_data, input out_ready);
	modport user (output in_valid, output in_data, input in_ready,
		input out_valid, input out_data, output out_ready);
endinterface : tsa_fifo_if

/* File: hw/tsa_fifo.sv */
// Module: small synchronous FIFO with valid/ready on both sides
`timescale 1ns/10ps
module tsa_fifo #(
	parameter int W = 1,
	parameter int DEPTH = 4
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Stream
	tsa_fifo_if.fifo s
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ff;
	logic [AW-1:0] rd_ff;
	logic [AW:0] cnt_ff;
	logic push;
	logic pop;

	// Handshakes; full and empty come from the true count
	assign s.in_ready = (cnt_ff != DEPTH[AW:0]);
	assign s.out_valid = (cnt_ff != '0);
	assign s.out_data = mem[rd_ff];
	assign push = s.in_valid && s.in_ready;
	assign pop = s.out_valid && s.out_ready;

	// Storage
	always_ff @(posedge core_clk) begin
		if (push) begin
			mem[wr_ff] <= s.in_data;
		end
	end

	// Pointers and count
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			wr_ff <= '0;
			rd_ff <= '0;
			cnt_ff <= '0;
		end else begin
			if (push) begin
				wr_ff <= (wr_ff == AW'(DEPTH - 1)) ? '0 : wr_ff + 1'b1;
			end
			if (pop) begin
				rd_ff <= (rd_ff == AW'(DEPTH - 1)) ? '0 : rd_ff + 1'b1;
			end
			cnt_ff <= cnt_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
		end
	end
endmodule : tsa_fifo

/* File: dv/tsa_highway_model.sv */
// Highway partner model: bit clock, frame sync, rx data, tx capture
`timescale 1ns/10ps
module tsa_highway_model (
	// Highway drive
	output logic hw_bit_clk,
	output logic frame_sync_in,
	output logic hw_rxd,
	// Highway observe
	input wire logic hw_txd_o,
	input wire logic hw_txd_oe
);
	logic tx_q[$];
	logic rx_q[$];
	// Bit clock parked high between frames
	initial begin
		hw_bit_clk = 1'b1;
		frame_sync_in = 1'b0;
		hw_rxd = 1'b1;
	end
	// Sync pulse, then nbits of 160 ns bit clock
	task automatic run_frame(input int nbits, input logic [15:0] pat);
		tx_q.delete();
		rx_q.delete();
		frame_sync_in = 1'b1;
		#80;
		for (int i = 0; i < nbits; i++) begin
			hw_bit_clk = 1'b0;
			hw_rxd = pat[i % 16];
			#80;
			hw_bit_clk = 1'b1;
			frame_sync_in = 1'b0;
			#78;
			// Late in the bit, so the delayed launch has settled
			if (hw_txd_oe === 1'b1) begin
				tx_q.push_back(hw_txd_o);
				rx_q.push_back(hw_rxd);
			end
			#2;
		end
		// Released line shows the inverse, never a stale level
		hw_rxd = ~hw_rxd;
	endtask : run_frame
endmodule : tsa_highway_model

/* File: dv/tb_tsa_time_slot_assigner.sv */
// Testbench: highway windows, fifo fill, underrun and direct mode
`timescale 1ns/10ps
module tb_tsa_time_slot_assigner;
	import tsa_pkg::*;
	logic core_clk, rst_n, highway_mode;
	logic [11:0] start_pos, stop_pos;
	logic hw_bit_clk, frame_sync_in, hw_rxd, hw_txd_o, hw_txd_oe;
	logic slot_buffer_enable, dce_rxd, dce_rclk, dce_txd, dce_tclk;
	logic hdlc_tx_bit, hdlc_tx_valid, hdlc_tx_ready;
	logic hdlc_rx_bit, hdlc_rx_valid, hdlc_bit_clk;
	int n_fail = 0;
	int checks_done = 0;
	int cycles = 0;
	logic rx_got[$];
	tsa_time_slot_assigner dut_u (.core_clk(core_clk), .rst_n(rst_n),
		.highway_mode(highway_mode), .start_pos(start_pos),
		.stop_pos(stop_pos), .hw_bit_clk(hw_bit_clk),
		.frame_sync_in(frame_sync_in), .hw_rxd(hw_rxd),
		.hw_txd_o(hw_txd_o), .hw_txd_oe(hw_txd_oe),
		.slot_buffer_enable(slot_buffer_enable), .dce_rxd(dce_rxd),
		.dce_rclk(dce_rclk), .dce_txd(dce_txd), .dce_tclk(dce_tclk),
		.hdlc_tx_bit(hdlc_tx_bit), .hdlc_tx_valid(hdlc_tx_valid),
		.hdlc_tx_ready(hdlc_tx_ready), .hdlc_rx_bit(hdlc_rx_bit),
		.hdlc_rx_valid(hdlc_rx_valid), .hdlc_bit_clk(hdlc_bit_clk));
	tsa_highway_model model_u (.hw_bit_clk(hw_bit_clk),
		.frame_sync_in(frame_sync_in), .hw_rxd(hw_rxd),
		.hw_txd_o(hw_txd_o), .hw_txd_oe(hw_txd_oe));
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic conclude();
		if (n_fail == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : conclude
	task automatic check(input string what, input logic [15:0] seen,
		input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	// One idle edge after each push, as ready lags a cycle
	task automatic push(input logic b);
		@(posedge core_clk);
		hdlc_tx_bit <= b;
		hdlc_tx_valid <= 1'b1;
		@(posedge core_clk);
		hdlc_tx_valid <= 1'b0;
		@(posedge core_clk);
	endtask : push
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic window(input logic [11:0] a, input logic [11:0] b,
		input logic [3:0] bits, input int nb, input int frames);
		int len;
		logic e;
		len = b - a + 1;
		@(posedge core_clk);
		highway_mode <= 1'b1;
		start_pos <= a;
		stop_pos <= b;
		for (int i = 0; i < nb; i++)
			push(bits[i]);
		@(negedge core_clk);
		check("tx_ready", hdlc_tx_ready, nb < 4);
		for (int f = 0; f < frames; f++) begin
			rx_got.delete();
			model_u.run_frame(b + 4, 16'hc5a3);
			repeat (8) @(posedge core_clk);
			check("tx_len", 16'(model_u.tx_q.size()), 16'(len));
			check("rx_len", 16'(rx_got.size()), 16'(len));
			for (int i = 0; i < model_u.tx_q.size(); i++) begin
				e = (f == 0 && i < nb) ? bits[i] : 1'b1;
				check("tx_bit", model_u.tx_q[i], e);
			end
			for (int i = 0; i < rx_got.size(); i++)
				check("rx_bit", rx_got[i], model_u.rx_q[i]);
		end
	endtask : window
	// Direct pins: 180 ns serial clocks made on core edges
	task automatic direct_path();
		@(posedge core_clk);
		highway_mode <= 1'b0;
		push(1'b0);
		push(1'b1);
		rx_got.delete();
		for (int i = 0; i < 2; i++) begin
			@(posedge core_clk);
			dce_tclk <= 1'b0;
			dce_rclk <= 1'b0;
			dce_rxd <= i[0];
			repeat (4) @(posedge core_clk);
			dce_tclk <= 1'b1;
			dce_rclk <= 1'b1;
			repeat (4) @(posedge core_clk);
			@(negedge core_clk);
			check("dce_txd", dce_txd, i[0]);
		end
		repeat (8) @(posedge core_clk);
		check("dce_rx_len", 16'(rx_got.size()), 16'd2);
		check("dce_rx", {rx_got[0], rx_got[1]}, 2'b01);
	endtask : direct_path
	// ----------------------------------------
	// Clock, monitors, sequence
	// ----------------------------------------
	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end
	// Collect every received bit the channel hands over
	always @(posedge core_clk) begin
		if (hdlc_rx_valid === 1'b1)
			rx_got.push_back(hdlc_rx_bit);
	end
	// Enable must track the tx drive at all times out of reset
	always @(negedge core_clk) begin
		if (rst_n === 1'b1)
			check("slot_enable", slot_buffer_enable, hw_txd_oe);
	end
	// Hang guard, far above the few hundred cycles needed
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_fail++;
			conclude();
		end
	end
	initial begin
		rst_n <= 1'b0;
		highway_mode <= 1'b0;
		start_pos <= 12'h000;
		stop_pos <= 12'h000;
		dce_rxd <= 1'b1;
		dce_rclk <= 1'b1;
		dce_tclk <= 1'b1;
		hdlc_tx_bit <= 1'b0;
		hdlc_tx_valid <= 1'b0;
		@(posedge core_clk);
		@(negedge core_clk);
		check("rst_oe", hw_txd_oe, 1'b0);
		check("rst_dce_txd", dce_txd, 1'b1);
		check("rst_rx_valid", hdlc_rx_valid, 1'b0);
		@(posedge core_clk);
		rst_n <= 1'b1;
		window(12'h002, 12'h007, 4'b0100, 4, 1);
		window(12'h005, 12'h005, 4'b0000, 1, 2);
		window(12'h009, 12'h010, 4'b1010, 4, 1);
		direct_path();
		conclude();
	end
endmodule : tb_tsa_time_slot_assigner
